// *** smcwp_top.sv ***
`timescale 1ns/100ps
module smcwp_top (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Serial link pins
    input wire logic sck,
    input wire logic cs_n,
    input wire logic si,
    output logic so,
    output logic so_oe,
    // Protect pin, low means protect
    input wire logic wp_n,
    // Nonvolatile block guard store
    input wire logic [1:0] nv_block_guard,
    output logic [1:0] nv_block_guard_wr,
    output logic nv_block_guard_we,
    // Wake status from the low power logic
    input wire logic waking,
    // Array write request from the data path
    input wire logic array_wr_req,
    input wire logic [smcwp_pkg::ADDR_W-1:0] array_wr_addr,
    output logic array_wr_ok,
    // Decoded command view for the rest of the device
    output logic [3:0] cmd_class,
    output logic cmd_valid,
    output logic [7:0] status_view
);
    import smcwp_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [4:0] pins_sync;
    logic sck_s;
    logic cs_n_s;
    logic si_s;
    logic wp_n_s;
    logic waking_s;
    logic sck_prev_ff;
    logic cs_prev_ff;
    logic sck_rise;
    logic sck_fall;
    logic cs_fall;
    logic cs_rise;
    smcwp_state_t state_ff;
    smcwp_state_t nxt_state;
    smcwp_cmd_t cmd_ff;
    logic [7:0] shift_ff;
    logic [2:0] bit_cnt_ff;
    logic byte_done;
    logic [7:0] rx_byte;
    logic wef_ff;
    logic pge_ff;
    logic [1:0] bg_ff;
    logic nv_loaded_ff;
    logic sr_byte_ok_ff;
    logic [7:0] sr_data_ff;
    logic [7:0] status_now;
    logic [7:0] tx_ff;
    logic status_lock;
    // Idle pin levels: select and protect high, the rest low, so the
    // edge detectors see no select edge when reset is released.
    localparam logic [4:0] PINS_IDLE = 5'h0A;

    // ------------------------------------------------------------
    // Opcode decoder
    // ------------------------------------------------------------
    // Maps the fifteen known opcodes onto command classes; any
    // other value is reserved and decodes as invalid.
    function automatic smcwp_cmd_t decode_op(input logic [7:0] op);
        smcwp_cmd_t c;
        c = CMD_INVALID;
        case (op)
            OP_LATCH_SET: c = CMD_LATCH_SET;
            OP_LATCH_CLEAR: c = CMD_LATCH_CLEAR;
            OP_STATUS_READ: c = CMD_STATUS_READ;
            OP_STATUS_WRITE: c = CMD_STATUS_WRITE;
            OP_ARRAY_WRITE: c = CMD_ARRAY_WRITE;
            OP_ARRAY_READ: c = CMD_READ_OTHER;
            OP_FAST_READ: c = CMD_FAST_READ;
            OP_SS_WRITE: c = CMD_SS_WRITE;
            OP_SS_READ: c = CMD_READ_OTHER;
            OP_DEV_ID_READ: c = CMD_READ_OTHER;
            OP_UNIQUE_ID_READ: c = CMD_READ_OTHER;
            OP_SN_WRITE: c = CMD_SN_WRITE;
            OP_SN_READ: c = CMD_READ_OTHER;
            OP_DEEP_SLEEP: c = CMD_LOW_POWER;
            OP_HIBERNATE: c = CMD_LOW_POWER;
            default: c = CMD_INVALID;
        endcase
        return c;
    endfunction

    // True for commands whose select rise drops the latch.
    function automatic logic ends_write(input smcwp_cmd_t c);
        return (c == CMD_LATCH_CLEAR) || (c == CMD_STATUS_WRITE) ||
            (c == CMD_ARRAY_WRITE) || (c == CMD_SS_WRITE) ||
            (c == CMD_SN_WRITE);
    endfunction

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    // The serial clock is sampled like any other pin, so the link
    // must run well below a quarter of clk for edges to be seen.
    smcwp_sync #(
        .WIDTH(5),
        .RST_VAL(PINS_IDLE)
    ) u_sync (
        .clk(clk),
        .rstn(rstn),
        .async_in({waking, wp_n, si, cs_n, sck}),
        .sync_out(pins_sync)
    );

    assign sck_s = pins_sync[0];
    assign cs_n_s = pins_sync[1];
    assign si_s = pins_sync[2];
    assign wp_n_s = pins_sync[3];
    assign waking_s = pins_sync[4];

    // ------------------------------------------------------------
    // Edge detection
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sck_prev_ff <= 1'b0;
            cs_prev_ff <= 1'b1;
        end
        else
        begin
            sck_prev_ff <= sck_s;
            cs_prev_ff <= cs_n_s;
        end
    end

    assign sck_rise = sck_s & ~sck_prev_ff & ~cs_n_s;
    assign sck_fall = ~sck_s & sck_prev_ff & ~cs_n_s;
    assign cs_fall = cs_prev_ff & ~cs_n_s;
    assign cs_rise = ~cs_prev_ff & cs_n_s;

    // ------------------------------------------------------------
    // Receive shifter and bit counter
    // ------------------------------------------------------------
    // The counter restarts at every select fall, so a mode 3 idle
    // high clock costs nothing: only rising edges are counted.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            shift_ff <= 8'h00;
            bit_cnt_ff <= 3'h0;
        end
        else if (cs_fall)
        begin
            shift_ff <= 8'h00;
            bit_cnt_ff <= 3'h0;
        end
        else if (sck_rise)
        begin
            shift_ff <= {shift_ff[6:0], si_s};
            bit_cnt_ff <= bit_cnt_ff + 3'h1;
        end
    end

    assign byte_done = sck_rise && (bit_cnt_ff == 3'(BYTE_BITS - 1));
    assign rx_byte = {shift_ff[6:0], si_s};

    // ------------------------------------------------------------
    // Command state machine
    // ------------------------------------------------------------
    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE:
                if (cs_fall)
                    nxt_state = ST_OPCODE;
            ST_OPCODE:
                if (cs_rise)
                    nxt_state = ST_IDLE;
                else if (byte_done)
                begin
                    if (decode_op(rx_byte) == CMD_STATUS_READ)
                        nxt_state = ST_STATUS_OUT;
                    else if (decode_op(rx_byte) == CMD_INVALID)
                        nxt_state = ST_IGNORE;
                    else
                        nxt_state = ST_DATA;
                end
            ST_DATA, ST_STATUS_OUT, ST_IGNORE:
                if (cs_rise)
                    nxt_state = ST_IDLE;
            default:
                nxt_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            state_ff <= ST_IDLE;
        else
            state_ff <= nxt_state;
    end

    // Holds the class of the one opcode taken in this select cycle.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cmd_ff <= CMD_NONE;
            cmd_valid <= 1'b0;
        end
        else if (cs_fall)
        begin
            cmd_ff <= CMD_NONE;
            cmd_valid <= 1'b0;
        end
        else if (state_ff == ST_OPCODE && byte_done)
        begin
            cmd_ff <= decode_op(rx_byte);
            cmd_valid <= 1'b1;
        end
    end

    assign cmd_class = cmd_ff;

    // ------------------------------------------------------------
    // Status write data capture
    // ------------------------------------------------------------
    // Only the first full data byte counts; a short frame leaves
    // the ready flag low so nothing is written.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sr_byte_ok_ff <= 1'b0;
            sr_data_ff <= 8'h00;
        end
        else if (cs_fall)
            sr_byte_ok_ff <= 1'b0;
        else if (state_ff == ST_DATA && cmd_ff == CMD_STATUS_WRITE &&
            byte_done && !sr_byte_ok_ff)
        begin
            sr_byte_ok_ff <= 1'b1;
            sr_data_ff <= rx_byte;
        end
    end

    // Status write is locked by a clear latch or by the pin guard
    // with the protect pin held low.
    assign status_lock = !wef_ff || (pge_ff && !wp_n_s);

    // ------------------------------------------------------------
    // Write enable latch
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            wef_ff <= 1'b0;
        else if (cs_rise && state_ff == ST_DATA && ends_write(cmd_ff))
            wef_ff <= 1'b0;
        else if (cs_rise && state_ff == ST_DATA &&
            cmd_ff == CMD_LATCH_SET)
            wef_ff <= 1'b1;
    end

    // ------------------------------------------------------------
    // Pin guard and block guard bits
    // ------------------------------------------------------------
    // The block guard copy is loaded from the nonvolatile store once
    // after reset; the pin guard is volatile and returns to zero.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            pge_ff <= SR_DELIVERED[SR_PGE_BIT];
            bg_ff <= {SR_DELIVERED[SR_BGH_BIT], SR_DELIVERED[SR_BGL_BIT]};
            nv_loaded_ff <= 1'b0;
            nv_block_guard_wr <= 2'h0;
            nv_block_guard_we <= 1'b0;
        end
        else
        begin
            nv_block_guard_we <= 1'b0;
            if (!nv_loaded_ff)
            begin
                bg_ff <= nv_block_guard;
                nv_loaded_ff <= 1'b1;
            end
            else if (cs_rise && cmd_ff == CMD_STATUS_WRITE &&
                sr_byte_ok_ff && !status_lock)
            begin
                pge_ff <= sr_data_ff[SR_PGE_BIT];
                bg_ff <= {sr_data_ff[SR_BGH_BIT], sr_data_ff[SR_BGL_BIT]};
                nv_block_guard_wr <= {sr_data_ff[SR_BGH_BIT],
                    sr_data_ff[SR_BGL_BIT]};
                nv_block_guard_we <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Status register image
    // ------------------------------------------------------------
    // Fixed bits come from the constant image; the latch flag is
    // read-only here, so a status write never reaches it.
    always_comb
    begin
        status_now = SR_FIXED_VAL;
        status_now[SR_PGE_BIT] = pge_ff;
        status_now[SR_BGH_BIT] = bg_ff[1];
        status_now[SR_BGL_BIT] = bg_ff[0];
        status_now[SR_WEF_BIT] = wef_ff;
        status_now[SR_BUSY_BIT] = waking_s;
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            status_view <= SR_DELIVERED;
        else
            status_view <= status_now;
    end

    // ------------------------------------------------------------
    // Array write permission
    // ------------------------------------------------------------
    // Only the latch and block guard field decide; pin and pin
    // guard play no part in array writes.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            array_wr_ok <= 1'b0;
        else if (!array_wr_req || !wef_ff)
            array_wr_ok <= 1'b0;
        else
        begin
            case (bg_ff)
                BG_NONE: array_wr_ok <= 1'b1;
                BG_QUARTER: array_wr_ok <= array_wr_addr < GUARD_QUARTER_BASE;
                BG_HALF: array_wr_ok <= array_wr_addr < GUARD_HALF_BASE;
                BG_ALL: array_wr_ok <= 1'b0;
                default: array_wr_ok <= 1'b0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Serial output
    // ------------------------------------------------------------
    // The status byte is loaded when the opcode completes and shifted
    // on falling edges, repeating for as long as clocks arrive.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            tx_ff <= 8'h00;
            so <= 1'b0;
            so_oe <= 1'b0;
        end
        else if (cs_n_s || state_ff == ST_IGNORE)
        begin
            so <= 1'b0;
            so_oe <= 1'b0;
        end
        else if (state_ff == ST_OPCODE && byte_done &&
            decode_op(rx_byte) == CMD_STATUS_READ)
            tx_ff <= status_now;
        else if (state_ff == ST_STATUS_OUT && sck_fall)
        begin
            so <= tx_ff[7];
            so_oe <= 1'b1;
            tx_ff <= (bit_cnt_ff == 3'(BYTE_BITS - 1)) ? status_now :
                {tx_ff[6:0], 1'b0};
        end
    end

endmodule

// *** smcwp_pkg.sv ***
// How it works
// - Opcode 06h sets the write enable latch.
// - Opcode 04h clears the write enable latch.
// - Decoder knows fifteen opcodes; others are invalid.
// - Opcode 0Bh decodes as fast read, valid up to 50 MHz.
// - Latch starts cleared after power-up.
// - Latch state reads as status bit 1.
// - Status write never sets the latch flag, only clears it.
// - Latch clears at select rise ending clear or write commands.
// - Clear latch blocks array and status writes.
// - Bits 0, 4, 5 read 0; bit 6 reads 1; none writable.
// - Bit 7 pin guard, bit 3 high and bit 2 low block guard.
// - Delivered status value is 40h.
// - Block guard bits persist across power loss.
// - Block guard field selects the protected address range.
// - Array writes depend on block guard and latch only.
// - Pin guard off means protect pin is ignored.
// - Pin guard on and pin low refuse status writes.
// - Bit 0 reads 0 except while waking from low power.
// - Select fall starts a command; first byte is the opcode.
// - Invalid opcode ignores input until next select fall.
// - Opcode 05h shifts status out, most significant bit first.
// - Opcode 01h updates pin guard and block guard bits.
package smcwp_pkg;

    // ------------------------------------------------------------
    // Opcodes
    // ------------------------------------------------------------
    localparam logic [7:0] OP_LATCH_SET = 8'h06;
    localparam logic [7:0] OP_LATCH_CLEAR = 8'h04;
    localparam logic [7:0] OP_STATUS_READ = 8'h05;
    localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
    localparam logic [7:0] OP_ARRAY_WRITE = 8'h02;
    localparam logic [7:0] OP_ARRAY_READ = 8'h03;
    localparam logic [7:0] OP_FAST_READ = 8'h0B;
    localparam logic [7:0] OP_SS_WRITE = 8'h42;
    localparam logic [7:0] OP_SS_READ = 8'h4B;
    localparam logic [7:0] OP_DEV_ID_READ = 8'h9F;
    localparam logic [7:0] OP_UNIQUE_ID_READ = 8'h4C;
    localparam logic [7:0] OP_SN_WRITE = 8'hC2;
    localparam logic [7:0] OP_SN_READ = 8'hC3;
    localparam logic [7:0] OP_DEEP_SLEEP = 8'hBA;
    localparam logic [7:0] OP_HIBERNATE = 8'hB9;

    // ------------------------------------------------------------
    // Status register layout
    // ------------------------------------------------------------
    localparam int SR_BUSY_BIT = 0;
    localparam int SR_WEF_BIT = 1;
    localparam int SR_BGL_BIT = 2;
    localparam int SR_BGH_BIT = 3;
    localparam int SR_PGE_BIT = 7;
    localparam logic [7:0] SR_FIXED_MASK = 8'h71;
    localparam logic [7:0] SR_FIXED_VAL = 8'h40;
    localparam logic [7:0] SR_DELIVERED = 8'h40;

    // ------------------------------------------------------------
    // Array geometry and guarded ranges
    // ------------------------------------------------------------
    localparam int ADDR_W = 18;
    localparam logic [17:0] GUARD_QUARTER_BASE = 18'h30000;
    localparam logic [17:0] GUARD_HALF_BASE = 18'h20000;
    localparam logic [17:0] ARRAY_TOP = 18'h3FFFF;
    localparam logic [1:0] BG_NONE = 2'h0;
    localparam logic [1:0] BG_QUARTER = 2'h1;
    localparam logic [1:0] BG_HALF = 2'h2;
    localparam logic [1:0] BG_ALL = 2'h3;

    // ------------------------------------------------------------
    // Link timing
    // ------------------------------------------------------------
    localparam int FAST_READ_MAX_MHZ = 50;
    localparam int BYTE_BITS = 8;

    // ------------------------------------------------------------
    // Decoded command classes
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        CMD_NONE = 4'h0,
        CMD_LATCH_SET = 4'h1,
        CMD_LATCH_CLEAR = 4'h2,
        CMD_STATUS_READ = 4'h3,
        CMD_STATUS_WRITE = 4'h4,
        CMD_ARRAY_WRITE = 4'h5,
        CMD_READ_OTHER = 4'h6,
        CMD_FAST_READ = 4'h7,
        CMD_SS_WRITE = 4'h8,
        CMD_SN_WRITE = 4'h9,
        CMD_LOW_POWER = 4'hA,
        CMD_INVALID = 4'hB
    } smcwp_cmd_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_OPCODE = 3'h1,
        ST_DATA = 3'h2,
        ST_STATUS_OUT = 3'h3,
        ST_IGNORE = 3'h4
    } smcwp_state_t;

endpackage

// *** smcwp_sync.sv ***
`timescale 1ns/100ps
module smcwp_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Signals from outside the clock domain
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_ff;

    // ------------------------------------------------------------
    // Two-stage synchroniser
    // ------------------------------------------------------------
    // The first stage feeds only the second, so a metastable value
    // never reaches logic.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            // Reset to each pin's idle level, so no false edge follows.
            meta_ff <= RST_VAL;
            sync_out <= RST_VAL;
        end
        else
        begin
            meta_ff <= async_in;
            sync_out <= meta_ff;
        end
    end

endmodule

// *** smcwp_top_assertions.sv ***
`timescale 1ns/100ps
module smcwp_top_assertions (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Link pins
    input wire logic cs_n,
    input wire logic wp_n,
    input wire logic so_oe,
    // Store, array gate and status outputs
    input wire logic nv_block_guard_we,
    input wire logic array_wr_req,
    input wire logic [smcwp_pkg::ADDR_W-1:0] array_wr_addr,
    input wire logic array_wr_ok,
    input wire logic [3:0] cmd_class,
    input wire logic cmd_valid,
    input wire logic [7:0] status_view
);
    import smcwp_pkg::*;

    // Every check lives in the system clock domain.
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rstn);

    // ------------------------------------------------------------
    // Status layout and latch timing
    // ------------------------------------------------------------
    AST_FIXED_BITS: assert property (status_view[6:4] == 3'b100)
        else $error("fixed status bits moved");
    // The latch may only move once the frame has ended.
    AST_LATCH_SET_AT_END: assert property
        ($rose(status_view[1]) |-> cs_n)
        else $error("latch set inside a frame");
    AST_LATCH_CLR_AT_END: assert property
        ($fell(status_view[1]) |-> cs_n)
        else $error("latch cleared inside a frame");

    // ------------------------------------------------------------
    // Serial output
    // ------------------------------------------------------------
    AST_INVALID_QUIET: assert property
        (cmd_valid && cmd_class == CMD_INVALID |-> !so_oe)
        else $error("output driven after an unknown opcode");
    AST_OE_RELEASE: assert property ($rose(cs_n) |-> ##[1:6] !so_oe)
        else $error("output still driven after deselect");

    // ------------------------------------------------------------
    // Array and status write gating
    // ------------------------------------------------------------
    // The status image lags one cycle, so the gate is tied to it then.
    AST_GATE_LATCH: assert property
        (array_wr_req ##1 !status_view[1] |-> !array_wr_ok)
        else $error("array write allowed with latch clear");
    AST_GATE_ALL: assert property
        (array_wr_req ##1 status_view[3:2] == BG_ALL |-> !array_wr_ok)
        else $error("array write allowed with all guarded");
    AST_GATE_HALF: assert property
        (array_wr_req && array_wr_addr >= GUARD_HALF_BASE ##1
        status_view[3] |-> !array_wr_ok)
        else $error("upper half write allowed");
    AST_GATE_QUARTER: assert property
        (array_wr_req && array_wr_addr >= GUARD_QUARTER_BASE ##1
        status_view[3:2] != BG_NONE |-> !array_wr_ok)
        else $error("upper quarter write allowed");
    AST_PIN_GUARD: assert property
        (nv_block_guard_we |-> wp_n || !status_view[7])
        else $error("status stored while pin guard holds");
endmodule

bind smcwp_top smcwp_top_assertions u_chk (
    .clk(clk), .rstn(rstn), .cs_n(cs_n), .wp_n(wp_n), .so_oe(so_oe),
    .nv_block_guard_we(nv_block_guard_we), .array_wr_req(array_wr_req),
    .array_wr_addr(array_wr_addr), .array_wr_ok(array_wr_ok),
    .cmd_class(cmd_class), .cmd_valid(cmd_valid),
    .status_view(status_view)
);

// *** smcwp_spi_master.sv ***
`timescale 1ns/100ps
module smcwp_spi_master (
    // Pins driven toward the device
    output logic sck,
    output logic cs_n,
    output logic si,
    // Reply pins from the device
    input wire logic so,
    input wire logic so_oe
);
    // Fires after the last bit, while select is still low.
    event tail;

    // The clock idles low between frames, as in mode 0.
    initial
    begin
        sck = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
    end

    // ------------------------------------------------------------
    // One select cycle: opcode, then nb bits of dat, MSB first
    // ------------------------------------------------------------
    task automatic frame(input logic [7:0] op, input logic [7:0] dat,
        input int nb, output logic [7:0] rd, output logic oe);
        logic [15:0] w;
        w = {op, dat};
        rd = 8'h00;
        oe = 1'b0;
        cs_n = 1'b0;
        #62.5;
        for (int i = 0; i < 8 + nb; i++)
        begin
            si = w[15 - i];
            #62.5;
            sck = 1'b1;
            rd = (i >= 8) ? {rd[6:0], so} : rd;
            oe = oe | (i >= 8 && so_oe);
            #62.5;
            sck = 1'b0;
        end
        -> tail;
        #200;
        // A released line must not keep showing the last bit.
        si = ~si;
        cs_n = 1'b1;
        #300;
    endtask
endmodule

// *** smcwp_tb_top.sv ***
`timescale 1ns/100ps
module smcwp_tb_top;
    import smcwp_pkg::*;

    // ------------------------------------------------------------
    // Signals and tables
    // ------------------------------------------------------------
    logic clk, rstn, sck, cs_n, si, so, so_oe, wp_n, waking;
    logic req, ok, we, vld, oe, vs;
    logic [1:0] nv_q, nv_wr;
    logic [17:0] addr;
    logic [3:0] cls_w, cls;
    logic [7:0] sv, rd;
    int num_errors = 0;
    int checks_done = 0;
    localparam logic [7:0] ops [16] = '{8'h06, 8'h04, 8'h05, 8'h01,
        8'h02, 8'h03, 8'h0B, 8'h42, 8'h4B, 8'h9F, 8'h4C, 8'hC2, 8'hC3,
        8'hBA, 8'hB9, 8'hA5};
    localparam smcwp_cmd_t exp_cls [16] = '{CMD_LATCH_SET,
        CMD_LATCH_CLEAR, CMD_STATUS_READ, CMD_STATUS_WRITE,
        CMD_ARRAY_WRITE, CMD_READ_OTHER, CMD_FAST_READ, CMD_SS_WRITE,
        CMD_READ_OTHER, CMD_READ_OTHER, CMD_READ_OTHER, CMD_SN_WRITE,
        CMD_READ_OTHER, CMD_LOW_POWER, CMD_LOW_POWER, CMD_INVALID};
    // Bit i is set where opcode i leaves the latch standing.
    localparam logic [15:0] keep = 16'hF765;
    localparam logic [17:0] adr [6] = '{18'h00000, 18'h1FFFF,
        18'h20000, 18'h2FFFF, 18'h30000, 18'h3FFFF};

    smcwp_top dut (
        .clk(clk), .rstn(rstn), .sck(sck), .cs_n(cs_n), .si(si),
        .so(so), .so_oe(so_oe), .wp_n(wp_n), .nv_block_guard(nv_q),
        .nv_block_guard_wr(nv_wr), .nv_block_guard_we(we),
        .waking(waking), .array_wr_req(req), .array_wr_addr(addr),
        .array_wr_ok(ok), .cmd_class(cls_w), .cmd_valid(vld),
        .status_view(sv)
    );
    smcwp_spi_master m (
        .sck(sck), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe)
    );

    // Clock generation.
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Nonvolatile store: keeps its value across resets.
    always @(posedge clk)
        if (we) nv_q <= nv_wr;

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Class is sampled before deselect, while it is surely current.
    task cmd(input logic [7:0] op, input logic [7:0] dat, input int nb);
        fork
            m.frame(op, dat, nb, rd, oe);
            begin
                @(m.tail);
                @(negedge clk);
                cls = cls_w;
                vs = vld;
            end
        join
    endtask

    task sw(input logic [7:0] d);
        cmd(8'h06, 8'h00, 0);
        cmd(8'h01, d, 8);
    endtask

    task arr(input logic [17:0] a, input logic e);
        @(negedge clk);
        req = 1'b1;
        addr = a;
        @(negedge clk);
        req = 1'b0;
        chk({7'h00, ok}, {7'h00, e});
    endtask

    task pin(input logic v);
        @(negedge clk);
        wp_n = v;
    endtask

    function logic prot(input logic [1:0] bg, input logic [17:0] a);
        return bg == 2'h3 || (bg == 2'h2 && a >= 18'h20000) ||
            (bg == 2'h1 && a >= 18'h30000);
    endfunction

    task results;
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial
    begin
        rstn = 1'b0;
        wp_n = 1'b1;
        waking = 1'b0;
        req = 1'b0;
        addr = 18'h00000;
        nv_q = 2'h0;
        repeat (5) @(negedge clk);
        rstn = 1'b1;
        repeat (4) @(negedge clk);
        chk(sv, 8'h40);
        cmd(8'h05, 8'h00, 8);
        chk(rd, 8'h40);
        chk({7'h00, oe}, 8'h01);
        $display("test reset done");
        for (int i = 0; i < 16; i++)
        begin
            cmd(8'h06, 8'h00, 0);
            cmd(ops[i], 8'h00, 8);
            chk({4'h0, cls}, {4'h0, exp_cls[i]});
            chk({7'h00, vs}, 8'h01);
            chk({7'h00, sv[1]}, {7'h00, keep[i]});
            if (ops[i] == 8'h05 || i == 15)
                chk({7'h00, oe}, (i == 15) ? 8'h00 : 8'h01);
        end
        $display("test decode done");
        sw(8'hFF);
        chk(sv, 8'hCC);
        cmd(8'h05, 8'h00, 8);
        chk(rd, 8'hCC);
        chk({6'h00, nv_q}, 8'h03);
        pin(1'b0);
        sw(8'h0C);
        chk(sv, 8'hCC);
        pin(1'b1);
        sw(8'h00);
        chk(sv, 8'h40);
        pin(1'b0);
        sw(8'h04);
        chk(sv, 8'h44);
        $display("test pin done");
        arr(18'h00000, 1'b0);
        for (int b = 0; b < 4; b++)
        begin
            sw({4'h0, b[1:0], 2'h0});
            cmd(8'h06, 8'h00, 0);
            for (int k = 0; k < 6; k++)
                arr(adr[k], !prot(b[1:0], adr[k]));
        end
        cmd(8'h04, 8'h00, 0);
        cmd(8'h05, 8'h00, 8);
        chk(rd, 8'h4C);
        cmd(8'h06, 8'h00, 0);
        cmd(8'h01, 8'h80, 5);
        chk(sv, 8'h4C);
        $display("test array done");
        @(negedge clk);
        waking = 1'b1;
        repeat (6) @(negedge clk);
        chk(sv, 8'h4D);
        waking = 1'b0;
        repeat (6) @(negedge clk);
        chk(sv, 8'h4C);
        sw(8'h08);
        @(negedge clk);
        rstn = 1'b0;
        repeat (5) @(negedge clk);
        rstn = 1'b1;
        repeat (4) @(negedge clk);
        chk(sv, 8'h48);
        $display("test restore done");
        results;
    end

    // About 60 frames of 1.6 to 2.6 us each; the limit leaves wide margin.
    initial
    begin
        #400_000;
        num_errors++;
        results;
    end
endmodule
